// file: rtl/tsrb_pkg.sv
`default_nettype none
package tsrb_pkg;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;
  localparam int STRB_W      = DATA_W / 8;
  typedef logic [ADDR_W-1:0] tsrb_addr_t;
  typedef logic [DATA_W-1:0] tsrb_word_t;

  // register byte offsets
  localparam tsrb_addr_t OFF_USER_CMD   = 12'h010;
  localparam tsrb_addr_t OFF_PATT_SEL   = 12'h014;
  localparam tsrb_addr_t OFF_FIFO_SPACE = 12'h124;
  localparam tsrb_addr_t OFF_SLOW_FEED  = 12'h128;
  localparam tsrb_addr_t OFF_EXP_W0     = 12'h130;
  localparam tsrb_addr_t OFF_EXP_W1     = 12'h134;
  localparam tsrb_addr_t OFF_EXP_W2     = 12'h138;
  localparam tsrb_addr_t OFF_EXP_W3     = 12'h13c;
  localparam tsrb_addr_t OFF_RDB_W0     = 12'h140;
  localparam tsrb_addr_t OFF_RDB_W1     = 12'h144;
  localparam tsrb_addr_t OFF_RDB_W2     = 12'h148;
  localparam tsrb_addr_t OFF_RDB_W3     = 12'h14c;
  localparam tsrb_addr_t OFF_FAIL_LO    = 12'h150;
  localparam tsrb_addr_t OFF_FAIL_HI    = 12'h154;
  localparam tsrb_addr_t OFF_DONE_LO    = 12'h158;
  localparam tsrb_addr_t OFF_DONE_HI    = 12'h15c;
  localparam tsrb_addr_t OFF_IRQ_STAT   = 12'h160;
  localparam tsrb_addr_t OFF_IRQ_MASK   = 12'h164;
  localparam tsrb_addr_t OFF_CSQ_BASE   = 12'h200;

  // custom submission entry window: 16 words, word index in addr[5:2]
  localparam int CSQ_WORDS   = 16;
  localparam int CSQ_SEL_LSB = 2;
  localparam int CSQ_SEL_W   = 4;
  localparam int CSQ_BLK_LSB = CSQ_SEL_LSB + CSQ_SEL_W;

  // user command and pattern select fields
  localparam int CMD_W       = 3;
  localparam logic [CMD_W-1:0] CMD_WRITE = 3'h2;
  localparam logic [CMD_W-1:0] CMD_READ  = 3'h3;
  localparam int PATT_W      = 4;
  localparam int VERIFY_BIT  = 3;

  // captured and mirrored quantities
  localparam int FIFO_CNT_W  = 10;
  localparam int PAT_DATA_W  = 128;
  localparam int FAIL_ADDR_W = 57;
  localparam int DONE_CNT_W  = 45;
  localparam int SLOW_BIT    = 0;

  // interrupt status / mask layout
  localparam int IRQ_W       = 2;
  localparam int IRQ_SLOW    = 0;
  localparam int IRQ_FAIL    = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

// file: rtl/tsrb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tsrb_top
  import tsrb_pkg::*;
(
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic [tsrb_pkg::ADDR_W-1:0]    s_axi_awaddr_in,
  input  wire logic                           s_axi_awvalid_in,
  output logic                                s_axi_awready_out,
  input  wire logic [tsrb_pkg::DATA_W-1:0]    s_axi_wdata_in,
  input  wire logic [tsrb_pkg::STRB_W-1:0]    s_axi_wstrb_in,
  input  wire logic                           s_axi_wvalid_in,
  output logic                                s_axi_wready_out,
  output logic [1:0]                          s_axi_bresp_out,
  output logic                                s_axi_bvalid_out,
  input  wire logic                           s_axi_bready_in,
  input  wire logic [tsrb_pkg::ADDR_W-1:0]    s_axi_araddr_in,
  input  wire logic                           s_axi_arvalid_in,
  output logic                                s_axi_arready_out,
  output logic [tsrb_pkg::DATA_W-1:0]         s_axi_rdata_out,
  output logic [1:0]                          s_axi_rresp_out,
  output logic                                s_axi_rvalid_out,
  input  wire logic                           s_axi_rready_in,
  input  wire logic [tsrb_pkg::FIFO_CNT_W-1:0] addr_fifo_free_count_in,
  input  wire logic                           addr_starve_in,
  input  wire logic                           cmp_valid_in,
  input  wire logic [tsrb_pkg::PAT_DATA_W-1:0] cmp_expected_in,
  input  wire logic [tsrb_pkg::PAT_DATA_W-1:0] cmp_readback_in,
  input  wire logic [tsrb_pkg::FAIL_ADDR_W-1:0] cmp_byte_addr_in,
  input  wire logic [tsrb_pkg::DONE_CNT_W-1:0] completed_cmd_counter_in,
  output logic [tsrb_pkg::CMD_W-1:0]          user_cmd_out,
  output logic                                user_cmd_strobe_out,
  output logic [tsrb_pkg::PATT_W-1:0]         pattern_select_out,
  output logic [tsrb_pkg::CSQ_WORDS*tsrb_pkg::DATA_W-1:0]
                                              custom_submit_dwords_out,
  output logic                                irq_out
);
  import tsrb_pkg::*;

  function automatic tsrb_word_t strb_merge(input tsrb_word_t old_v,
                                            input tsrb_word_t new_v,
                                            input logic [STRB_W-1:0] strb);
    tsrb_word_t res;
    res = old_v;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic tsrb_word_t word_of(input logic [PAT_DATA_W-1:0] v,
                                         input int unsigned idx);
    return v[idx*DATA_W +: DATA_W];
  endfunction

  function automatic logic in_csq(input tsrb_addr_t a);
    return a[ADDR_W-1:CSQ_BLK_LSB] == OFF_CSQ_BASE[ADDR_W-1:CSQ_BLK_LSB];
  endfunction

  // bus slave state
  logic                     awready_r;
  logic                     wready_r;
  logic                     bvalid_r;
  logic [1:0]               bresp_r;
  logic                     arready_r;
  logic                     rvalid_r;
  logic [1:0]               rresp_r;
  tsrb_word_t               rdata_r;
  logic                     aw_held_r;
  logic                     w_held_r;
  tsrb_addr_t               aw_addr_r;
  tsrb_word_t               w_data_r;
  logic [STRB_W-1:0]        w_strb_r;

  // register state
  logic [CMD_W-1:0]         user_cmd_r;
  logic                     cmd_strobe_r;
  logic [PATT_W-1:0]        patt_r;
  logic                     slow_r;
  logic                     fail_seen_r;
  logic [PAT_DATA_W-1:0]    exp_r;
  logic [PAT_DATA_W-1:0]    rdb_r;
  logic [FAIL_ADDR_W-1:0]   fail_addr_r;
  logic [IRQ_W-1:0]         irq_stat_r;
  logic [IRQ_W-1:0]         irq_mask_r;
  logic                     irq_r;
  logic [CSQ_WORDS-1:0][DATA_W-1:0] csq_r;

  logic                     wr_go;
  logic                     wr_hit;
  logic                     cmd_wr;
  logic                     cmd_rw;
  logic                     cmd_rd;
  logic                     slow_set;
  logic                     fail_set;
  tsrb_word_t               rd_data;
  logic                     rd_hit;
  logic [IRQ_W-1:0]         irq_clr;
  logic [IRQ_W-1:0]         irq_set;
  logic [IRQ_W-1:0]         irq_stat_nxt;

  assign s_axi_awready_out        = awready_r;
  assign s_axi_wready_out         = wready_r;
  assign s_axi_bvalid_out         = bvalid_r;
  assign s_axi_bresp_out          = bresp_r;
  assign s_axi_arready_out        = arready_r;
  assign s_axi_rvalid_out         = rvalid_r;
  assign s_axi_rresp_out          = rresp_r;
  assign s_axi_rdata_out          = rdata_r;
  assign user_cmd_out             = user_cmd_r;
  assign user_cmd_strobe_out      = cmd_strobe_r;
  assign pattern_select_out       = patt_r;
  assign custom_submit_dwords_out = csq_r;
  assign irq_out                  = irq_r;

  // a write commits once both address and data have been taken
  assign wr_go  = aw_held_r && w_held_r;
  assign cmd_wr = wr_go && (aw_addr_r == OFF_USER_CMD) && w_strb_r[0];
  assign cmd_rw = cmd_wr && ((w_data_r[CMD_W-1:0] == CMD_WRITE) ||
                             (w_data_r[CMD_W-1:0] == CMD_READ));
  assign cmd_rd = cmd_wr && (w_data_r[CMD_W-1:0] == CMD_READ);
  assign slow_set = addr_starve_in;
  assign fail_set = cmp_valid_in && patt_r[VERIFY_BIT] &&
                    (cmp_expected_in != cmp_readback_in) &&
                    (!fail_seen_r || cmd_rd);

  // read-only offsets still decode, so writes to them answer okay and
  // are dropped rather than raising a decode error
  always_comb begin
    case (aw_addr_r)
      OFF_USER_CMD, OFF_PATT_SEL, OFF_FIFO_SPACE, OFF_SLOW_FEED,
      OFF_EXP_W0, OFF_EXP_W1, OFF_EXP_W2, OFF_EXP_W3,
      OFF_RDB_W0, OFF_RDB_W1, OFF_RDB_W2, OFF_RDB_W3,
      OFF_FAIL_LO, OFF_FAIL_HI, OFF_DONE_LO, OFF_DONE_HI,
      OFF_IRQ_STAT, OFF_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = in_csq(aw_addr_r);
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && awready_r) begin
        aw_addr_r <= s_axi_awaddr_in;
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid_in && wready_r) begin
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      // channels reopen only after the response is accepted
      if (bvalid_r && s_axi_bready_in) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // read mux; capture registers are sliced at read time
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    case (s_axi_araddr_in)
      OFF_USER_CMD:   rd_data = DATA_W'(user_cmd_r);
      OFF_PATT_SEL:   rd_data = DATA_W'(patt_r);
      OFF_FIFO_SPACE: rd_data = DATA_W'(addr_fifo_free_count_in);
      OFF_SLOW_FEED:  rd_data[SLOW_BIT] = slow_r;
      OFF_EXP_W0:     rd_data = word_of(exp_r, 0);
      OFF_EXP_W1:     rd_data = word_of(exp_r, 1);
      OFF_EXP_W2:     rd_data = word_of(exp_r, 2);
      OFF_EXP_W3:     rd_data = word_of(exp_r, 3);
      OFF_RDB_W0:     rd_data = word_of(rdb_r, 0);
      OFF_RDB_W1:     rd_data = word_of(rdb_r, 1);
      OFF_RDB_W2:     rd_data = word_of(rdb_r, 2);
      OFF_RDB_W3:     rd_data = word_of(rdb_r, 3);
      OFF_FAIL_LO:    rd_data = fail_addr_r[DATA_W-1:0];
      OFF_FAIL_HI:
        rd_data = DATA_W'(fail_addr_r[FAIL_ADDR_W-1:DATA_W]);
      OFF_DONE_LO:
        rd_data = completed_cmd_counter_in[DATA_W-1:0];
      OFF_DONE_HI:
        rd_data = DATA_W'(completed_cmd_counter_in[DONE_CNT_W-1:DATA_W]);
      OFF_IRQ_STAT:   rd_data = DATA_W'(irq_stat_r);
      OFF_IRQ_MASK:   rd_data = DATA_W'(irq_mask_r);
      // the submission entry is write-only and reads back as zero
      default:        rd_hit = in_csq(s_axi_araddr_in);
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (s_axi_arvalid_in && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_data;
      rresp_r   <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // user command and pattern select
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      user_cmd_r   <= '0;
      cmd_strobe_r <= 1'b0;
      patt_r       <= '0;
    end else begin
      cmd_strobe_r <= cmd_wr;
      if (cmd_wr) begin
        user_cmd_r <= w_data_r[CMD_W-1:0];
      end
      if (wr_go && (aw_addr_r == OFF_PATT_SEL) && w_strb_r[0]) begin
        patt_r <= w_data_r[PATT_W-1:0];
      end
    end
  end

  // slow-feed flag: a starve in the clearing cycle keeps it set
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slow_r <= 1'b0;
    end else if (slow_set) begin
      slow_r <= 1'b1;
    end else if (cmd_rw) begin
      slow_r <= 1'b0;
    end
  end

  // first-mismatch capture; a new read command re-arms it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fail_seen_r <= 1'b0;
      exp_r       <= '0;
      rdb_r       <= '0;
      fail_addr_r <= '0;
    end else if (fail_set) begin
      fail_seen_r <= 1'b1;
      exp_r       <= cmp_expected_in;
      rdb_r       <= cmp_readback_in;
      fail_addr_r <= cmp_byte_addr_in;
    end else if (cmd_rd) begin
      fail_seen_r <= 1'b0;
    end
  end

  // submission entry words; capture registers have no write path at all
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      csq_r <= '0;
    end else if (wr_go && in_csq(aw_addr_r)) begin
      csq_r[aw_addr_r[CSQ_BLK_LSB-1:CSQ_SEL_LSB]] <=
        strb_merge(csq_r[aw_addr_r[CSQ_BLK_LSB-1:CSQ_SEL_LSB]],
                   w_data_r, w_strb_r);
    end
  end

  // interrupt status, write-one-to-clear; new events win over the clear
  always_comb begin
    irq_clr = '0;
    if (wr_go && (aw_addr_r == OFF_IRQ_STAT) && w_strb_r[0]) begin
      irq_clr = w_data_r[IRQ_W-1:0];
    end
    irq_set           = '0;
    irq_set[IRQ_SLOW] = slow_set && !slow_r;
    irq_set[IRQ_FAIL] = fail_set;
    irq_stat_nxt      = (irq_stat_r & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_go && (aw_addr_r == OFF_IRQ_MASK) && w_strb_r[0]) begin
        irq_mask_r <= w_data_r[IRQ_W-1:0];
      end
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_slow_clear: assert property (
    cmd_rw && !slow_set |=> !slow_r)
    else $error("slow-feed flag not cleared by command write");

  a_slow_set: assert property (
    slow_set |=> slow_r)
    else $error("slow-feed flag not set by starve");

  a_first_capture: assert property (
    fail_set |=> exp_r == $past(cmp_expected_in) &&
                 rdb_r == $past(cmp_readback_in) &&
                 fail_addr_r == $past(cmp_byte_addr_in))
    else $error("mismatch not captured");

  a_capture_hold: assert property (
    fail_seen_r && !cmd_rd |=> fail_seen_r && $stable(exp_r) &&
                               $stable(rdb_r) && $stable(fail_addr_r))
    else $error("first mismatch capture overwritten");

  a_verify_gate: assert property (
    !patt_r[VERIFY_BIT] && !fail_seen_r |=> !fail_seen_r)
    else $error("capture with verification disabled");

  a_ro_ignore: assert property (
    wr_go && aw_addr_r >= OFF_EXP_W0 && aw_addr_r <= OFF_FAIL_HI &&
    !fail_set |=> $stable(exp_r) && $stable(rdb_r) && $stable(fail_addr_r))
    else $error("write changed a read-only capture");

  a_csq_store: assert property (
    wr_go && in_csq(aw_addr_r) && &w_strb_r |=>
      csq_r[$past(aw_addr_r[CSQ_BLK_LSB-1:CSQ_SEL_LSB])] == $past(w_data_r))
    else $error("submission word not stored");

  a_fifo_read: assert property (
    s_axi_arvalid_in && arready_r && s_axi_araddr_in == OFF_FIFO_SPACE |=>
      rvalid_r && rdata_r == DATA_W'($past(addr_fifo_free_count_in)))
    else $error("fifo space read wrong");

  a_bresp_after: assert property (
    wr_go |=> bvalid_r [*1] ##0 !aw_held_r && !w_held_r)
    else $error("write response missing");

  a_irq_level: assert property (
    (|(irq_stat_r & irq_mask_r)) && !wr_go |=> irq_r)
    else $error("interrupt not raised");

endmodule
`default_nettype wire

// file: test/tsrb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tsrb_top_tb;
  import tsrb_pkg::*;
  logic                   clk_in, rst_n_in;
  logic [ADDR_W-1:0]      s_axi_awaddr_in, s_axi_araddr_in;
  logic                   s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic                   s_axi_arvalid_in, s_axi_rready_in;
  logic [DATA_W-1:0]      s_axi_wdata_in, s_axi_rdata_out;
  logic [STRB_W-1:0]      s_axi_wstrb_in;
  logic                   s_axi_awready_out, s_axi_wready_out;
  logic                   s_axi_bvalid_out;
  logic                   s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0]             s_axi_bresp_out, s_axi_rresp_out;
  logic [FIFO_CNT_W-1:0]  addr_fifo_free_count_in;
  logic                   addr_starve_in, cmp_valid_in;
  logic [PAT_DATA_W-1:0]  cmp_expected_in, cmp_readback_in;
  logic [FAIL_ADDR_W-1:0] cmp_byte_addr_in;
  logic [DONE_CNT_W-1:0]  completed_cmd_counter_in;
  logic [CMD_W-1:0]       user_cmd_out;
  logic                   user_cmd_strobe_out, irq_out;
  logic [PATT_W-1:0]      pattern_select_out;
  logic [CSQ_WORDS*DATA_W-1:0] custom_submit_dwords_out;
  int                     n_mismatch, n_compared;
  tsrb_word_t             d;
  logic [1:0]             r;
  localparam logic [127:0] E1 = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
  localparam logic [127:0] R1 = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f1;
  localparam logic [127:0] E2 = 128'h11112222_33334444_55556666_77778888;
  localparam logic [127:0] R2 = 128'h99990000_aaaabbbb_ccccdddd_eeeeffff;
  localparam logic [56:0]  A1 = 57'h1a5_5aa5_1234_5678;
  localparam logic [56:0]  A2 = 57'h0f0_0000_0000_1000;

  tsrb_top dut_u (
    .clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .addr_fifo_free_count_in, .addr_starve_in, .cmp_valid_in,
    .cmp_expected_in, .cmp_readback_in, .cmp_byte_addr_in,
    .completed_cmd_counter_in, .user_cmd_out, .user_cmd_strobe_out,
    .pattern_select_out, .custom_submit_dwords_out, .irq_out
  );

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input tsrb_word_t e,
                     input tsrb_word_t g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // address and data are offered together and each dropped once taken
  task automatic wr(input tsrb_addr_t a, input tsrb_word_t v,
                    output logic [1:0] rs);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wdata_in <= v;
    s_axi_wstrb_in <= 4'hf;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_in);
      if (!aw_ok && s_axi_awready_out === 1'b1) begin
        s_axi_awvalid_in <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && s_axi_wready_out === 1'b1) begin
        s_axi_wvalid_in <= 1'b0;
        w_ok = 1'b1;
      end
    end
    @(posedge clk_in);
    while (s_axi_bvalid_out !== 1'b1) @(posedge clk_in);
    rs = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic rd(input tsrb_addr_t a, output tsrb_word_t v,
                    output logic [1:0] rs);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    @(posedge clk_in);
    while (s_axi_arready_out !== 1'b1) @(posedge clk_in);
    s_axi_arvalid_in <= 1'b0;
    @(posedge clk_in);
    while (s_axi_rvalid_out !== 1'b1) @(posedge clk_in);
    v = s_axi_rdata_out;
    rs = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input tsrb_addr_t a,
                        input tsrb_word_t e);
    rd(a, d, r);
    chk(nm, e, d);
    chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic starve_pulse();
    @(posedge clk_in);
    addr_starve_in <= 1'b1;
    @(posedge clk_in);
    addr_starve_in <= 1'b0;
  endtask

  task automatic mismatch(input logic [127:0] e, input logic [127:0] g,
                          input logic [56:0] a);
    @(posedge clk_in);
    cmp_valid_in <= 1'b1;
    cmp_expected_in <= e;
    cmp_readback_in <= g;
    cmp_byte_addr_in <= a;
    @(posedge clk_in);
    cmp_valid_in <= 1'b0;
  endtask

  task automatic capture_chk(input logic [127:0] e, input logic [127:0] g,
                             input logic [56:0] a);
    for (int i = 0; i < 4; i++) begin
      rd_chk("expected word", OFF_EXP_W0 + tsrb_addr_t'(4 * i), e[32*i +: 32]);
      rd_chk("readback word", OFF_RDB_W0 + tsrb_addr_t'(4 * i), g[32*i +: 32]);
    end
    rd_chk("fail addr low", OFF_FAIL_LO, a[31:0]);
    rd_chk("fail addr high", OFF_FAIL_HI, {7'h0, a[56:32]});
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    summarize();
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst_n_in = 1'b0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, addr_starve_in, cmp_valid_in} = '0;
    {cmp_expected_in, cmp_readback_in, cmp_byte_addr_in} = '0;
    addr_fifo_free_count_in = 10'h2a5;
    completed_cmd_counter_in = 45'habc_1234_5678;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk("fifo space", OFF_FIFO_SPACE, 32'h0000_02a5);
    rd_chk("done count low", OFF_DONE_LO, 32'h1234_5678);
    rd_chk("done count high", OFF_DONE_HI, 32'h0000_0abc);
    wr(OFF_FIFO_SPACE, 32'hffff_ffff, r);
    chk("ro write response", {30'h0, RESP_OKAY}, {30'h0, r});
    rd_chk("fifo space kept", OFF_FIFO_SPACE, 32'h0000_02a5);
    addr_fifo_free_count_in <= 10'h3ff;
    completed_cmd_counter_in <= 45'h1fff_0000_0001;
    rd_chk("fifo space live", OFF_FIFO_SPACE, 32'h0000_03ff);
    rd_chk("done count high live", OFF_DONE_HI, 32'h0000_1fff);
    $display("test live status done");

    starve_pulse();
    rd_chk("slow flag set", OFF_SLOW_FEED, 32'h0000_0001);
    rd_chk("irq status", OFF_IRQ_STAT, 32'h0000_0001);
    wr(OFF_IRQ_MASK, 32'h0000_0001, r);
    repeat (2) @(posedge clk_in);
    chk("irq raised", 32'h1, {31'h0, irq_out});
    wr(OFF_IRQ_STAT, 32'h0000_0001, r);
    repeat (2) @(posedge clk_in);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
    wr(OFF_IRQ_MASK, 32'h0000_0000, r);
    // only the write and read codes may clear the flag
    for (int c = 0; c < 8; c++) begin
      starve_pulse();
      wr(OFF_USER_CMD, tsrb_word_t'(c), r);
      chk("user command", tsrb_word_t'(c), {29'h0, user_cmd_out});
      chk("command strobe", 32'h1, {31'h0, user_cmd_strobe_out});
      @(posedge clk_in);
      chk("strobe fell", 32'h0, {31'h0, user_cmd_strobe_out});
      rd_chk("slow flag", OFF_SLOW_FEED,
             (c == 2 || c == 3) ? 32'h0 : 32'h1);
    end
    $display("test slow feed done");

    wr(OFF_PATT_SEL, 32'h0000_0000, r);
    mismatch(E1, R1, A1);
    capture_chk('0, '0, '0);
    wr(OFF_PATT_SEL, 32'h0000_0008, r);
    chk("pattern select", 32'h8, {28'h0, pattern_select_out});
    mismatch(E1, R1, A1);
    capture_chk(E1, R1, A1);
    rd_chk("irq status both", OFF_IRQ_STAT, 32'h0000_0003);
    mismatch(E2, R2, A2);
    capture_chk(E1, R1, A1);
    wr(OFF_EXP_W0, 32'hffff_ffff, r);
    wr(OFF_FAIL_HI, 32'hffff_ffff, r);
    capture_chk(E1, R1, A1);
    wr(OFF_USER_CMD, {29'h0, CMD_READ}, r);
    mismatch(E2, R2, A2);
    capture_chk(E2, R2, A2);
    $display("test capture done");

    for (int i = 0; i < CSQ_WORDS; i++) begin
      wr(OFF_CSQ_BASE + tsrb_addr_t'(4 * i),
         32'hc500_0000 | tsrb_word_t'(i), r);
    end
    wr(OFF_USER_CMD, 32'h0000_0004, r);
    chk("smart command", 32'h4, {29'h0, user_cmd_out});
    for (int i = 0; i < CSQ_WORDS; i++) begin
      chk("submit dword", 32'hc500_0000 | tsrb_word_t'(i),
          custom_submit_dwords_out[32*i +: 32]);
    end
    rd_chk("submit readback", OFF_CSQ_BASE + 12'h03c, 32'h0);
    wr(12'h300, 32'h1234_5678, r);
    chk("unmapped write response", {30'h0, RESP_DECERR}, {30'h0, r});
    rd(12'h300, d, r);
    chk("unmapped read response", {30'h0, RESP_DECERR}, {30'h0, r});
    chk("unmapped read data", 32'h0, d);
    $display("test submit entry done");
    summarize();
  end
endmodule
`default_nettype wire
